// [rtl/sdm_monitor.v]
`timescale 1ns/1ps
`include "sdm_regs.vh"
module sdm_monitor #(
  parameter DATA_W = `SDM_DATA_W,
  parameter TEST_CYCLES = `SDM_TEST_CYCLES
) (
  input wire ref_clk,
  input wire rst,
  input wire meas_start,
  input wire meas_done,
  input wire [DATA_W-1:0] x_result,
  input wire [DATA_W-1:0] y_result,
  input wire [DATA_W-1:0] z_result,
  input wire [DATA_W-1:0] temp_result,
  input wire x_limit_check_en,
  input wire y_limit_check_en,
  input wire z_limit_check_en,
  input wire temp_limit_check_en,
  input wire [DATA_W-1:0] x_field_limit_value,
  input wire [DATA_W-1:0] y_field_limit_value,
  input wire [DATA_W-1:0] z_field_limit_value,
  input wire [DATA_W-1:0] temp_limit_value,
  input wire selftest_enable,
  input wire [1:0] selftest_schedule,
  input wire limit_alert_en,
  input wire selftest_alert_en,
  input wire flag_clear,
  input wire bridge_in_tol,
  input wire offset_in_tol,
  input wire [2:0] hall_in_tol,
  input wire bandgap_in_tol,
  output reg x_field_limit_flag,
  output reg y_field_limit_flag,
  output reg z_field_limit_flag,
  output reg temp_limit_flag,
  output reg signal_path_fault,
  output reg x_hall_element_fault,
  output reg y_hall_element_fault,
  output reg z_hall_element_fault,
  output reg converter_fault,
  output reg path_busy,
  output reg hall_disconnect,
  output reg conv_allowed,
  output reg eval_done,
  output reg alert_toggle
);
// ----------------------------------------
// signed crossing test
// ----------------------------------------
function crossed;
  input [DATA_W-1:0] val;
  input [DATA_W-1:0] lim;
  begin
    crossed = ($signed(val) > $signed(lim));
  end
endfunction
// ----------------------------------------
// state
// ----------------------------------------
reg [2:0] state_reg;
reg [7:0] cnt_reg;
reg [1:0] meas_cnt_reg;
reg run_tests;
reg pre_phase;
reg post_phase;
wire [2:0] hall_fail;
assign hall_fail = ~hall_in_tol;
always @*
begin
  case (selftest_schedule)
    `SDM_SCHED_BEFORE: run_tests = 1'b1;
    `SDM_SCHED_AFTER: run_tests = 1'b1;
    `SDM_SCHED_ALT: run_tests = ~meas_cnt_reg[0];
    `SDM_SCHED_EVERY_4: run_tests = (meas_cnt_reg == 2'h0);
    default: run_tests = 1'b0;
  endcase
  pre_phase = selftest_enable && run_tests && (selftest_schedule != `SDM_SCHED_AFTER);
  post_phase = selftest_enable && run_tests && (selftest_schedule == `SDM_SCHED_AFTER);
end
// ----------------------------------------
// sequencer
// ----------------------------------------
always @(posedge ref_clk)
begin
  if (rst)
  begin
    state_reg <= `SDM_ST_IDLE;
    cnt_reg <= 8'h00;
    meas_cnt_reg <= 2'h0;
    path_busy <= 1'b0;
    hall_disconnect <= 1'b0;
    conv_allowed <= 1'b0;
    eval_done <= 1'b0;
  end
  else
  begin
    eval_done <= 1'b0;
    case (state_reg)
      `SDM_ST_IDLE:
      begin
        if (meas_start)
        begin
          if (pre_phase)
          begin
            state_reg <= `SDM_ST_PRE;
            cnt_reg <= TEST_CYCLES;
            path_busy <= 1'b1;
            hall_disconnect <= 1'b1;
          end
          else
          begin
            state_reg <= `SDM_ST_MEAS;
            conv_allowed <= 1'b1;
          end
        end
      end
      `SDM_ST_PRE:
      begin
        if (cnt_reg == 8'h01)
        begin
          state_reg <= `SDM_ST_MEAS;
          path_busy <= 1'b0;
          hall_disconnect <= 1'b0;
          conv_allowed <= 1'b1;
        end
        cnt_reg <= cnt_reg - 8'h01;
      end
      `SDM_ST_MEAS:
      begin
        if (meas_done)
        begin
          conv_allowed <= 1'b0;
          meas_cnt_reg <= meas_cnt_reg + 2'h1;
          if (post_phase)
          begin
            state_reg <= `SDM_ST_POST;
            cnt_reg <= TEST_CYCLES;
            path_busy <= 1'b1;
            hall_disconnect <= 1'b1;
          end
          else
          begin
            state_reg <= `SDM_ST_DONE;
          end
        end
      end
      `SDM_ST_POST:
      begin
        if (cnt_reg == 8'h01)
        begin
          state_reg <= `SDM_ST_DONE;
          path_busy <= 1'b0;
          hall_disconnect <= 1'b0;
        end
        cnt_reg <= cnt_reg - 8'h01;
      end
      `SDM_ST_DONE:
      begin
        state_reg <= `SDM_ST_IDLE;
        eval_done <= 1'b1;
      end
      default:
      begin
        state_reg <= `SDM_ST_IDLE;
      end
    endcase
  end
end
// ----------------------------------------
// fault evaluation
// ----------------------------------------
wire test_end;
wire lim_eval;
wire [3:0] lim_hit;
wire [4:0] st_hit;
assign test_end = selftest_enable && path_busy && (cnt_reg == 8'h01) &&
  ((state_reg == `SDM_ST_PRE) || (state_reg == `SDM_ST_POST));
assign lim_eval = (state_reg == `SDM_ST_MEAS) && meas_done;
assign lim_hit[0] = lim_eval && x_limit_check_en &&
  crossed(x_result, x_field_limit_value);
assign lim_hit[1] = lim_eval && y_limit_check_en &&
  crossed(y_result, y_field_limit_value);
assign lim_hit[2] = lim_eval && z_limit_check_en &&
  crossed(z_result, z_field_limit_value);
assign lim_hit[3] = lim_eval && temp_limit_check_en &&
  crossed(temp_result, temp_limit_value);
assign st_hit[0] = test_end && (~bridge_in_tol || ~offset_in_tol);
assign st_hit[3:1] = {3{test_end}} & hall_fail;
assign st_hit[4] = test_end && ~bandgap_in_tol;
always @(posedge ref_clk)
begin
  if (rst)
  begin
    x_field_limit_flag <= 1'b0;
    y_field_limit_flag <= 1'b0;
    z_field_limit_flag <= 1'b0;
    temp_limit_flag <= 1'b0;
    signal_path_fault <= 1'b0;
    x_hall_element_fault <= 1'b0;
    y_hall_element_fault <= 1'b0;
    z_hall_element_fault <= 1'b0;
    converter_fault <= 1'b0;
    alert_toggle <= 1'b0;
  end
  else
  begin
    // set wins over clear
    x_field_limit_flag <= lim_hit[0] | (x_field_limit_flag & ~flag_clear);
    y_field_limit_flag <= lim_hit[1] | (y_field_limit_flag & ~flag_clear);
    z_field_limit_flag <= lim_hit[2] | (z_field_limit_flag & ~flag_clear);
    temp_limit_flag <= lim_hit[3] | (temp_limit_flag & ~flag_clear);
    signal_path_fault <= st_hit[0] | (signal_path_fault & ~flag_clear);
    x_hall_element_fault <= st_hit[1] | (x_hall_element_fault & ~flag_clear);
    y_hall_element_fault <= st_hit[2] | (y_hall_element_fault & ~flag_clear);
    z_hall_element_fault <= st_hit[3] | (z_hall_element_fault & ~flag_clear);
    converter_fault <= st_hit[4] | (converter_fault & ~flag_clear);
    if ((limit_alert_en && (|lim_hit)) || (selftest_alert_en && (|st_hit)))
      alert_toggle <= ~alert_toggle;
  end
end
endmodule // sdm_monitor

// [rtl/sdm_regs.vh]
`ifndef SDM_REGS_VH
`define SDM_REGS_VH
// ----------------------------------------
// widths
// ----------------------------------------
`define SDM_DATA_W 16
// ----------------------------------------
// schedule encodings
// ----------------------------------------
`define SDM_SCHED_W 2
`define SDM_SCHED_BEFORE 2'h0
`define SDM_SCHED_AFTER 2'h1
`define SDM_SCHED_ALT 2'h2
`define SDM_SCHED_EVERY_4 2'h3
// ----------------------------------------
// self-test phase lengths
// ----------------------------------------
`define SDM_TEST_CYCLES 8'h08
// ----------------------------------------
// state codes
// ----------------------------------------
`define SDM_ST_IDLE 3'h0
`define SDM_ST_PRE 3'h1
`define SDM_ST_MEAS 3'h2
`define SDM_ST_POST 3'h3
`define SDM_ST_DONE 3'h4
`endif

// [verif/sdm_monitor_chk.sv]
`timescale 1ns/1ps
// ----
// monitor checker
// ----
module sdm_chk #(parameter int TEST_CYCLES = 8) (
  input wire ref_clk,
  input wire rst,
  input wire meas_done,
  input wire conv_allowed,
  input wire path_busy,
  input wire hall_disconnect,
  input wire x_limit_check_en,
  input wire x_field_limit_flag,
  input wire signal_path_fault,
  input wire converter_fault,
  input wire bandgap_in_tol,
  input wire selftest_enable,
  input wire alert_toggle,
  input wire limit_alert_en,
  input wire selftest_alert_en,
  input wire [15:0] x_result,
  input wire [15:0] x_field_limit_value
);
  localparam int TL = TEST_CYCLES - 1;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence busy_run;
    path_busy ##TL path_busy ##1 !path_busy;
  endsequence
  x_limit_a: assert property (meas_done && conv_allowed && x_limit_check_en &&
    $signed(x_result) > $signed(x_field_limit_value) |=> x_field_limit_flag)
    else $error("x flag missed");
  x_source_a: assert property ($rose(x_field_limit_flag) |->
    $past(meas_done && x_limit_check_en)) else $error("x flag unsourced");
  busy_conv_a: assert property (path_busy |-> !conv_allowed)
    else $error("conversion while busy");
  hall_conv_a: assert property (hall_disconnect |-> !conv_allowed)
    else $error("conversion on hall test");
  busy_len_a: assert property ($rose(path_busy) |-> busy_run)
    else $error("test phase length");
  path_fault_a: assert property ($rose(signal_path_fault) |->
    $past(path_busy && selftest_enable)) else $error("path fault unsourced");
  conv_fault_a: assert property ($rose(converter_fault) |->
    $past(path_busy && !bandgap_in_tol)) else $error("converter fault unsourced");
  alert_src_a: assert property ($changed(alert_toggle) |->
    $past(limit_alert_en || selftest_alert_en)) else $error("alert ungated");
  hall_sep_a: assert property (path_busy |-> hall_disconnect)
    else $error("hall not parted in test");
endmodule // sdm_chk
bind sdm_monitor sdm_chk #(.TEST_CYCLES(TEST_CYCLES)) u_chk (.*);

// [verif/sdm_ctl_model.sv]
`timescale 1ns/1ps
// ----
// controller: starts a measurement, ends it when allowed
// ----
module sdm_ctl_model (
  input wire ref_clk,
  input wire go,
  input wire conv_allowed,
  output logic meas_start = 1'b0,
  output logic meas_done = 1'b0
);
  logic run = 1'b0;
  always @(negedge ref_clk)
  begin
    meas_start <= go && !run;
    meas_done <= run && conv_allowed && !meas_done;
    if (go) run <= 1'b1;
    if (meas_done) run <= 1'b0;
  end
endmodule // sdm_ctl_model

// [verif/sdm_tb.sv]
`timescale 1ns/1ps
`include "sdm_regs.vh"
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin err_count++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb;
  logic ref_clk = 1'b0, rst = 1'b1, go = 1'b0, flag_clear = 1'b0, selftest_enable = 1'b0;
  logic limit_alert_en = 1'b1, selftest_alert_en = 1'b0, offset_in_tol = 1'b1;
  logic bridge_in_tol = 1'b1, bandgap_in_tol = 1'b1, x_limit_check_en = 1'b1;
  logic y_limit_check_en = 1'b0, z_limit_check_en = 1'b1, temp_limit_check_en = 1'b1;
  logic [1:0] selftest_schedule = 2'h0;
  logic [2:0] hall_in_tol = 3'h7;
  logic [15:0] x_result = 16'h0100, y_result = 16'h0100, z_result = 16'h0040;
  logic [15:0] temp_result = 16'h0090, x_field_limit_value = 16'h00ff;
  logic [15:0] y_field_limit_value = 16'h0000, z_field_limit_value = 16'h0040;
  logic [15:0] temp_limit_value = 16'h0080;
  logic meas_start, meas_done, x_field_limit_flag, y_field_limit_flag, z_field_limit_flag;
  logic temp_limit_flag, signal_path_fault, x_hall_element_fault, y_hall_element_fault;
  logic z_hall_element_fault, converter_fault, path_busy, hall_disconnect, conv_allowed;
  logic eval_done, alert_toggle;
  int err_count = 0, total_checks = 0, cyc = 0;
  int lat_sum = 0, busy_sum = 0;
  int runs[4] = '{4, 4, 2, 1};
  wire [3:0] lf = {x_field_limit_flag, y_field_limit_flag, z_field_limit_flag, temp_limit_flag};
  wire [5:0] sf = {signal_path_fault, x_hall_element_fault, y_hall_element_fault,
    z_hall_element_fault, converter_fault, alert_toggle};
  sdm_monitor dut (.*);
  sdm_ctl_model ctl (.*);
  initial forever #50 ref_clk = ~ref_clk;
  task print_verdict;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic meas;
    int n;
    n = 0;
    @(negedge ref_clk) go <= 1'b1;
    @(negedge ref_clk) go <= 1'b0;
    while (eval_done !== 1'b1 && n < 60)
    begin
      @(negedge ref_clk);
      n++;
      if (path_busy === 1'b1)
        busy_sum++;
    end
    lat_sum += n;
    `CHK(eval_done, 1'b1)
  endtask
  task clr;
    @(negedge ref_clk) flag_clear <= 1'b1;
    @(negedge ref_clk) flag_clear <= 1'b0;
  endtask
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      err_count++;
      print_verdict;
    end
  end
  initial
  begin
    repeat (12) @(negedge ref_clk);
    rst = 1'b0;
    meas;
    `CHK(lf, 4'h9)
    `CHK(alert_toggle, 1'b1)
    $display("limit test done");
    clr;
    limit_alert_en = 1'b0;
    x_result = 16'h8000;
    z_result = 16'hfff0;
    z_field_limit_value = 16'hffe0;
    y_limit_check_en = 1'b1;
    meas;
    `CHK(lf, 4'h7)
    `CHK(alert_toggle, 1'b1)
    $display("signed test done");
    selftest_enable = 1'b1;
    selftest_alert_en = 1'b1;
    for (int s = 0; s < 4; s++)
    begin
      selftest_schedule = s[1:0];
      lat_sum = 0;
      busy_sum = 0;
      repeat (4) meas;
      `CHK(lat_sum, 12 + runs[s] * `SDM_TEST_CYCLES)
      `CHK(busy_sum, runs[s] * `SDM_TEST_CYCLES)
    end
    `CHK(sf, 6'h01)
    selftest_schedule = 2'h0;
    bridge_in_tol = 1'b0;
    hall_in_tol = 3'h5;
    bandgap_in_tol = 1'b0;
    meas;
    `CHK(sf, 6'h2a)
    clr;
    bridge_in_tol = 1'b1;
    hall_in_tol = 3'h7;
    bandgap_in_tol = 1'b1;
    offset_in_tol = 1'b0;
    meas;
    `CHK(sf, 6'h21)
    clr;
    selftest_enable = 1'b0;
    bridge_in_tol = 1'b0;
    hall_in_tol = 3'h0;
    bandgap_in_tol = 1'b0;
    meas;
    `CHK(sf, 6'h01)
    $display("self test done");
    rst = 1'b1;
    repeat (2) @(negedge ref_clk);
    `CHK({lf, sf}, 10'h000)
    rst = 1'b0;
    meas;
    `CHK({lf, sf}, 10'h1c0)
    $display("reset test done");
    print_verdict;
  end
endmodule // tb
